// *** sim/cpsp_bb_model.sv ***
// baseband model: free link clock, tx frame sender, rx frame catcher
// assumes sdr capture; a rising strobe marks each received frame
`timescale 1ns/100ps
module cpsp_bb_model (
	output logic        tck,
	output logic        ts,
	output logic        td,
	input  wire logic   rck,
	input  wire logic   rs,
	input  wire logic   rd,
	output logic [31:0] rx_pair,
	output int          rx_hi,
	output int          rx_cnt
);
	logic [31:0] sh;    // rx shift register
	int          n;     // bits of current frame
	int          hi;    // strobe-high bits so far
	logic        sprev; // strobe at last bit
	// idle values
	initial begin
		tck = 1'b0;
		ts = 1'b0;
		td = 1'b0;
		n = 0;
		sprev = 1'b0;
		rx_cnt = 0;
	end
	// link clock runs free: the port's sync needs it
	always #15 tck = ~tck;
	// one frame, bit 31 of w first, changed off the sampling edge
	task automatic send(input logic [31:0] w, input logic lvl);
		for (int i = 0; i < 32; i++) begin
			@(negedge tck);
			ts <= lvl ? (i < 16) : (i == 0);
			td <= w[31-i];
		end
		@(negedge tck);
		ts <= 1'b0;
		td <= ~td; // stale line flips, no last-value hold
	endtask : send
	// catch rx frames on the rising rx clock
	always @(posedge rck) begin
		if (rs && !sprev) begin
			n = 1;
			sh = {31'h0, rd};
			hi = 1;
		end else if (n > 0) begin
			sh = {sh[30:0], rd};
			hi += int'(rs);
			n++;
		end
		sprev = rs;
		if (n == 32) begin
			rx_pair = sh;
			rx_hi = hi;
			rx_cnt++;
			n = 0;
		end
	end
endmodule : cpsp_bb_model

// *** sim/tb.sv ***
// self-checking bench of the serial i/q port
// assumes zero-wait ahb slave and the baseband model
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	$display("mismatch %s exp %h got %h", nm, e, g); num_errors++; end end
module tb
	import cpsp_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, hrdata, rv, rx_pair;
	logic [1:0]  htrans;
	logic        hreadyout, hresp, tck, ts, td, tref, rck, rs, rd;
	int          rx_hi, rx_cnt, num_errors, samples_checked;
	// device under test, hready looped from hreadyout
	cpsp_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .tx_bit_clock_input(tck),
		.tx_strobe_input(ts), .tx_data_input(td),
		.tx_reference_clock_output(tref), .rx_bit_clock_output(rck),
		.rx_strobe_output(rs), .rx_data_output(rd));
	cpsp_bb_model u_bb (.tck(tck), .ts(ts), .td(td), .rck(rck), .rs(rs),
		.rd(rd), .rx_pair(rx_pair), .rx_hi(rx_hi), .rx_cnt(rx_cnt));
	always #2.5 hclk = ~hclk;
	// wire order of a pair for a given config
	function automatic logic [31:0] ord(logic [31:0] p, logic qf, logic lsb);
		logic [15:0] a, b;
		a = qf ? p[15:0] : p[31:16];
		b = qf ? p[31:16] : p[15:0];
		if (lsb) begin
			a = {<<{a}};
			b = {<<{b}};
		end
		return {a, b};
	endfunction : ord
	// one single transfer; entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask : bus
	task automatic chk_rd(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(nm, e, rv)
	endtask : chk_rd
	// reset values, access kinds, unmapped place
	task automatic t_regs();
		chk_rd("ctrl", OFF_CTRL, 32'h0);
		chk_rd("clkdiv", OFF_CLKDIV, {16'h0, DIV_RST});
		bus(1'b1, OFF_DELAY, 32'h77);
		chk_rd("delay", OFF_DELAY, 32'h77);
		bus(1'b1, OFF_DELAY, 32'h0);
		bus(1'b1, 8'h18, 32'h5a5a5a5a);
		chk_rd("unmapped", 8'h18, 32'h0);
	endtask : t_regs
	// rx frames in a given order, strobe shape and trim
	task automatic t_rx(input logic qf, lsb, lvl, input logic [2:0] dl,
		input logic [31:0] p);
		int c0;
		bus(1'b1, OFF_RXSMP, p);
		bus(1'b1, OFF_DELAY, {29'h0, dl});
		bus(1'b1, OFF_CTRL, {28'h0, lvl, lsb, qf, 1'b1});
		c0 = rx_cnt;
		for (int i = 0; i < 2000 && rx_cnt < c0 + 2; i++) @(posedge hclk);
		`CHK("rx frames", 1'b1, rx_cnt >= c0 + 2)
		`CHK("rx pair", ord(p, qf, lsb), rx_pair)
		`CHK("rx strobe bits", lvl ? 16 : 1, rx_hi)
		bus(1'b1, OFF_CTRL, 32'h0);
		repeat (12) @(posedge hclk);
		`CHK("rx idle", 3'h0, {rck, rs, rd})
	endtask : t_rx
	// tx frame rebuilt into a pair
	task automatic t_tx(input logic qf, lsb, lvl, input logic [31:0] p);
		logic [15:0] n0;
		bus(1'b1, OFF_CTRL, {22'h0, 1'b0, lvl, lsb, qf, 1'b1, 5'h0});
		bus(1'b0, OFF_STATUS, 32'h0);
		n0 = rv[15:0];
		u_bb.send(ord(p, qf, lsb), lvl);
		@(posedge hclk);
		for (int i = 0; i < 60 && rv[15:0] !== n0 + 16'h1; i++)
			bus(1'b0, OFF_STATUS, 32'h0);
		`CHK("tx count", n0 + 16'h1, rv[15:0])
		chk_rd("tx pair", OFF_TXSMP, p);
	endtask : t_tx
	// clock rates, then pads handed to the other mode
	task automatic t_clk();
		int nr, nt;
		nr = 0;
		nt = 0;
		bus(1'b1, OFF_CTRL, 32'h801);
		repeat (10) @(posedge hclk);
		for (int i = 0; i < 40; i++) begin
			@(posedge hclk);
			nr += int'(rck);
			nt += int'(tref);
		end
		`CHK("rx clk highs", 20, nr)
		`CHK("ref clk highs", 20, nt)
		bus(1'b1, OFF_CTRL, 32'hc01);
		repeat (12) @(posedge hclk);
		`CHK("lvds idle", 2'h0, {rck, tref})
	endtask : t_clk
	task automatic conclude();
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	// main sequence
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		num_errors = 0;
		samples_checked = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_rx(1'b0, 1'b0, 1'b0, 3'h0, 32'h1234abcd);
		t_rx(1'b1, 1'b1, 1'b0, 3'h3, 32'h8001c3a5);
		t_rx(1'b0, 1'b0, 1'b1, 3'h0, 32'hf00f5aa5);
		t_tx(1'b0, 1'b0, 1'b0, 32'h13579bdf);
		t_tx(1'b1, 1'b1, 1'b0, 32'hc001d00d);
		t_tx(1'b0, 1'b0, 1'b1, 32'h2468ace0);
		t_clk();
		conclude();
	end
	// hang guard, far beyond the expected run
	initial begin
		#200000;
		num_errors++;
		conclude();
	end
endmodule : tb

// *** src/cpsp_pkg.sv ***
// constants and types of the one-lane cmos serial i/q sample port
// assumes a 200 mhz hclk and a software map on a 32-bit ahb-lite bus
package cpsp_pkg;
	// byte offsets of the register map
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_DELAY  = 8'h04;
	localparam logic [7:0] OFF_CLKDIV = 8'h08;
	localparam logic [7:0] OFF_RXSMP  = 8'h0c;
	localparam logic [7:0] OFF_TXSMP  = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	// control field positions
	localparam int CTRL_RX_EN  = 0;
	localparam int CTRL_RX_QF  = 1;
	localparam int CTRL_RX_LSB = 2;
	localparam int CTRL_RX_LVL = 3;
	localparam int CTRL_RX_DDR = 4;
	localparam int CTRL_TX_EN  = 5;
	localparam int CTRL_TX_QF  = 6;
	localparam int CTRL_TX_LSB = 7;
	localparam int CTRL_TX_LVL = 8;
	localparam int CTRL_TX_DDR = 9;
	localparam int CTRL_LVDS   = 10;
	localparam int CTRL_REF_EN = 11;
	localparam int CTRL_W      = 12;
	// delay field positions
	localparam int DLY_RX_LSB = 0;
	localparam int DLY_TX_LSB = 4;
	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
	localparam logic [7:0]        DLY_RST  = 8'h00;
	localparam logic [15:0]       DIV_RST  = 16'h0202;
	// framing
	localparam int FRAME_BITS = 32;
	localparam int WORD_BITS  = 16;
	localparam int DLY_STEPS  = 7;
	// timing: hclk rate and highest port clock
	localparam int CLK_MHZ      = 200;
	localparam int PORT_MAX_MHZ = 80;
	// least half period of the port clock, rounded up
	localparam logic [7:0] HALF_MIN =
		8'((CLK_MHZ + 2 * PORT_MAX_MHZ - 1) / (2 * PORT_MAX_MHZ));
	// receive serializer states
	typedef enum logic {RX_OFF, RX_RUN} cpsp_rx_e;
	// deserializer state carried through one bit step
	typedef struct packed {
		logic [5:0]  cnt;
		logic [31:0] sh;
		logic        sprev;
		logic        done;
	} cpsp_des_s;
endpackage : cpsp_pkg

// *** src/cpsp_tap_delay.sv ***
// selectable 0..7 step delay line for strobe and data
// assumes sel is quasi-static on clk; latency is sel plus one cycle
`timescale 1ns/100ps
module cpsp_tap_delay
	import cpsp_pkg::*;
#(
	parameter int W = 2
)(
	input  wire logic clk,
	input  wire logic rst_n,
	cpsp_tap_if.line  tap
);
	logic [W-1:0] pipe_r [DLY_STEPS];  // tap chain
	logic [W-1:0] dout_r;              // selected tap

	// chain head
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pipe_r[0] <= '0;
		end else begin
			pipe_r[0] <= tap.din;
		end
	end

	// remaining chain stages
	for (genvar k = 1; k < DLY_STEPS; k++) begin : g_stage
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				pipe_r[k] <= '0;
			end else begin
				pipe_r[k] <= pipe_r[k-1];
			end
		end
	end

	// output tap, registered so the phase step stays clean
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dout_r <= '0;
		end else if (tap.sel == 3'h0) begin
			dout_r <= tap.din;
		end else begin
			dout_r <= pipe_r[tap.sel - 3'h1];
		end
	end
	assign tap.dout = dout_r;

	property p_dly0;
		@(posedge clk) disable iff (!rst_n)
		(tap.sel == 3'h0) |=> (tap.dout == $past(tap.din));
	endproperty
	a_dly0: assert property (p_dly0)
		else $error("zero step delay is not one cycle");

	property p_dly7;
		@(posedge clk) disable iff (!rst_n)
		(tap.sel == 3'h7)[*8] |-> (tap.dout == $past(tap.din, 8));
	endproperty
	a_dly7: assert property (p_dly7)
		else $error("seven step delay is not eight cycles");
endmodule : cpsp_tap_delay

// *** src/cpsp_tap_if.sv ***
// bundle between the port logic and a strobe/data delay line
// assumes both ends sit on the same clock
`timescale 1ns/100ps
interface cpsp_tap_if #(parameter int W = 2);
	logic [W-1:0] din;   // undelayed strobe/data
	logic [2:0]   sel;   // extra delay steps
	logic [W-1:0] dout;  // delayed strobe/data
	modport src  (output din, output sel, input dout);
	modport line (input din, input sel, output dout);
endinterface : cpsp_tap_if

// *** src/cpsp_top.sv ***
// one-lane cmos serial i/q port: receive serializer, transmit
// deserializer, reference clock and ahb-lite register slave
// assumes a single ahb master, pads outside, tx link clock free running
// Behaviour
// - rx port drives clock, strobe, data
// - 32-bit frame, selectable word and bit order
// - pulse strobe: high first bit only
// - level strobe: high for i, low q
// - rx clock times rx strobe and data
// - tx captures strobe, data on link clock
// - tx rebuilds pair in configured order
// - optional tx reference clock output
// - 0..7 step strobe/data delay trim
// - pads shared, lvds select idles cmos port
// - sdr or ddr, clock at most 80 mhz
`timescale 1ns/100ps
module cpsp_top
	import cpsp_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        tx_bit_clock_input,
	input  wire logic        tx_strobe_input,
	input  wire logic        tx_data_input,
	output logic             tx_reference_clock_output,
	output logic             rx_bit_clock_output,
	output logic             rx_strobe_output,
	output logic             rx_data_output
);
	// reverse bit order of one word
	function automatic logic [15:0] rev16(input logic [15:0] w);
		logic [15:0] r;
		r = 16'h0000;
		for (int k = 0; k < WORD_BITS; k++) begin
			r[k] = w[WORD_BITS-1-k];
		end
		return r;
	endfunction : rev16

	// one deserializer bit step
	function automatic cpsp_des_s des_step(input cpsp_des_s st,
		input logic s, input logic d, input logic lvl, input logic qf);
		cpsp_des_s r;
		logic      start;
		r = st;
		// level mode: edge into the first word marks the frame
		start = lvl ? ((s & ~st.sprev & ~qf) | (~s & st.sprev & qf)) : s;
		r.sprev = s;
		r.done = 1'b0;
		r.sh = {st.sh[30:0], d};
		if (start) begin
			r.cnt = 6'h01;
		end else if (st.cnt != 6'h00) begin
			r.cnt = st.cnt + 6'h01;
		end
		if (r.cnt == 6'(FRAME_BITS)) begin
			r.done = 1'b1;
			r.cnt = 6'h00;
		end
		return r;
	endfunction : des_step

	logic [CTRL_W-1:0] ctrl_r;      // control bits
	logic [7:0]        dly_r;       // delay trim fields
	logic [15:0]       div_r;       // half periods rx / ref
	logic [31:0]       rxs_r;       // next rx pair {i,q}
	logic [31:0]       txs_r;       // last tx pair {i,q}
	logic [15:0]       rx_frames_r; // frames sent
	logic [15:0]       tx_frames_r; // frames taken
	logic              ap_wr_r;     // write data phase pending
	logic [7:0]        ap_addr_r;   // latched address
	logic [31:0]       rd_mux;      // read data select
	logic              ap_take;     // address phase accepted

	assign ap_take = hsel & htrans[1] & hready;

	// read mux on the address phase, unmapped reads as zero
	always_comb begin
		unique case (haddr[7:0])
			OFF_CTRL:   rd_mux = {20'h00000, ctrl_r};
			OFF_DELAY:  rd_mux = {24'h000000, dly_r};
			OFF_CLKDIV: rd_mux = {16'h0000, div_r};
			OFF_RXSMP:  rd_mux = rxs_r;
			OFF_TXSMP:  rd_mux = txs_r;
			OFF_STATUS: rd_mux = {rx_frames_r, tx_frames_r};
			default:    rd_mux = 32'h00000000;
		endcase
	end

	// bus slave: zero wait, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_r   <= 1'b0;
			ap_addr_r <= 8'h00;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			ap_wr_r <= ap_take & hwrite;
			if (ap_take) begin
				ap_addr_r <= haddr[7:0];
			end
			if (ap_take & ~hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// software writes in the data phase; read-only words ignore it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= CTRL_RST;
			dly_r  <= DLY_RST;
			div_r  <= DIV_RST;
			rxs_r  <= 32'h00000000;
		end else if (ap_wr_r) begin
			unique case (ap_addr_r)
				OFF_CTRL:   ctrl_r <= hwdata[CTRL_W-1:0];
				OFF_DELAY:  dly_r  <= {1'b0, hwdata[6:4], 1'b0, hwdata[2:0]};
				OFF_CLKDIV: div_r  <= hwdata[15:0];
				OFF_RXSMP:  rxs_r  <= hwdata;
				default:    ;
			endcase
		end
	end

	// ---- receive serializer on hclk ----
	logic       port_on;   // cmos owns the pads
	logic       rx_go;     // serializer enabled
	logic [7:0] rx_half;   // clamped half period
	logic [7:0] ref_half;  // clamped ref half period
	cpsp_rx_e   rx_st_r;
	logic [7:0] rx_cnt_r;  // cycles in this half period
	logic       rx_clk_r;  // internal bit clock
	logic [4:0] rx_idx_r;  // bit index in frame
	logic [31:0] rx_frame_r;
	logic       rx_stb_q;
	logic       rx_dat_q;
	logic       rx_tick;   // half period ends
	logic       rx_shift;  // bit boundary
	logic       rx_load;   // new frame due
	logic [4:0] rx_idx_nxt;
	logic [31:0] rx_frame_nxt;
	logic       rx_stb_nxt;
	logic       rx_clk_d_r; // clock matched to zero-step tap latency

	assign port_on  = ~ctrl_r[CTRL_LVDS];
	assign rx_go    = port_on & ctrl_r[CTRL_RX_EN];
	// faster settings would break the port clock limit
	assign rx_half  = (div_r[7:0] < HALF_MIN) ? HALF_MIN : div_r[7:0];
	assign ref_half = (div_r[15:8] < HALF_MIN) ? HALF_MIN : div_r[15:8];
	assign rx_tick  = (rx_st_r == RX_RUN) && (rx_cnt_r == rx_half - 8'h01);
	// sdr moves on the falling edge, ddr on both
	assign rx_shift = rx_tick & (ctrl_r[CTRL_RX_DDR] | rx_clk_r);
	assign rx_load  = (rx_st_r == RX_OFF) || (rx_idx_r == 5'h1f);

	// next frame word, next index and next strobe
	always_comb begin
		logic [15:0] fw;
		logic [15:0] sw;
		fw = ctrl_r[CTRL_RX_QF] ? rxs_r[15:0] : rxs_r[31:16];
		sw = ctrl_r[CTRL_RX_QF] ? rxs_r[31:16] : rxs_r[15:0];
		if (ctrl_r[CTRL_RX_LSB]) begin
			fw = rev16(fw);
			sw = rev16(sw);
		end
		rx_idx_nxt   = rx_load ? 5'h00 : rx_idx_r + 5'h01;
		rx_frame_nxt = rx_load ? {fw, sw} : rx_frame_r;
		if (ctrl_r[CTRL_RX_LVL]) begin
			rx_stb_nxt = ~rx_idx_nxt[4] ^ ctrl_r[CTRL_RX_QF];
		end else begin
			rx_stb_nxt = (rx_idx_nxt == 5'h00);
		end
	end

	// serializer state, clock divider and bit shifting
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_st_r    <= RX_OFF;
			rx_cnt_r   <= 8'h00;
			rx_clk_r   <= 1'b0;
			rx_idx_r   <= 5'h00;
			rx_frame_r <= 32'h00000000;
			rx_stb_q   <= 1'b0;
			rx_dat_q   <= 1'b0;
		end else if (!rx_go) begin
			rx_st_r  <= RX_OFF;
			rx_cnt_r <= 8'h00;
			rx_clk_r <= 1'b0;
			rx_idx_r <= 5'h00;
			rx_stb_q <= 1'b0;
			rx_dat_q <= 1'b0;
		end else begin
			rx_cnt_r <= rx_tick ? 8'h00 : rx_cnt_r + 8'h01;
			if (rx_tick) begin
				rx_clk_r <= ~rx_clk_r;
			end
			if (rx_st_r == RX_OFF || rx_shift) begin
				rx_st_r    <= RX_RUN;
				rx_idx_r   <= rx_idx_nxt;
				rx_frame_r <= rx_frame_nxt;
				rx_stb_q   <= rx_stb_nxt;
				rx_dat_q   <= rx_frame_nxt[~rx_idx_nxt];
			end
		end
	end

	// sent frame count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_frames_r <= 16'h0000;
		end else if (rx_go && (rx_st_r == RX_OFF || (rx_shift && rx_load))) begin
			rx_frames_r <= rx_frames_r + 16'h0001;
		end
	end

	// strobe/data trim; the clock takes the zero-step latency
	cpsp_tap_if #(.W(2)) rx_tap ();
	assign rx_tap.din = {rx_stb_q, rx_dat_q};
	assign rx_tap.sel = dly_r[DLY_RX_LSB +: 3];
	cpsp_tap_delay #(.W(2)) u_rx_dly (
		.clk   (hclk),
		.rst_n (hresetn),
		.tap   (rx_tap)
	);

	// output flops, held low while lvds owns the pads
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_clk_d_r          <= 1'b0;
			rx_bit_clock_output <= 1'b0;
			rx_strobe_output    <= 1'b0;
			rx_data_output      <= 1'b0;
		end else begin
			rx_clk_d_r          <= rx_clk_r;
			rx_bit_clock_output <= rx_go & rx_clk_d_r;
			rx_strobe_output    <= rx_go & rx_tap.dout[1];
			rx_data_output      <= rx_go & rx_tap.dout[0];
		end
	end

	// ---- transmit reference clock ----
	logic [7:0] ref_cnt_r;
	logic       ref_on;
	assign ref_on = port_on & ctrl_r[CTRL_REF_EN];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_cnt_r                 <= 8'h00;
			tx_reference_clock_output <= 1'b0;
		end else if (!ref_on) begin
			ref_cnt_r                 <= 8'h00;
			tx_reference_clock_output <= 1'b0;
		end else if (ref_cnt_r == ref_half - 8'h01) begin
			ref_cnt_r                 <= 8'h00;
			tx_reference_clock_output <= ~tx_reference_clock_output;
		end else begin
			ref_cnt_r <= ref_cnt_r + 8'h01;
		end
	end

	// ---- transmit deserializer on the link clock ----
	logic [1:0]  lrst_r;      // link reset release
	logic        link_rst_n;
	logic [7:0]  tcfg_s1_r;   // config sync, first stage
	logic [7:0]  tcfg_r;      // {dly, ddr, lvl, lsb, qf, en}
	logic [1:0]  pos_r;       // rising edge sample
	logic [1:0]  neg_r;       // falling edge sample
	cpsp_des_s   des_r;
	cpsp_des_s   des_a;
	cpsp_des_s   des_b;
	logic [31:0] tx_word_r;   // rebuilt pair {i,q}
	logic        tx_tog_r;    // flips per rebuilt pair

	assign link_rst_n = lrst_r[1];
	always_ff @(posedge tx_bit_clock_input or negedge hresetn) begin
		if (!hresetn) begin
			lrst_r <= 2'b00;
		end else begin
			lrst_r <= {lrst_r[0], 1'b1};
		end
	end

	// config is quasi-static, so a plain two-flop pass is enough
	always_ff @(posedge tx_bit_clock_input or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tcfg_s1_r <= 8'h00;
			tcfg_r    <= 8'h00;
		end else begin
			tcfg_s1_r <= {dly_r[DLY_TX_LSB +: 3], ctrl_r[CTRL_TX_DDR],
				ctrl_r[CTRL_TX_LVL], ctrl_r[CTRL_TX_LSB],
				ctrl_r[CTRL_TX_QF], ctrl_r[CTRL_TX_EN] & port_on};
			tcfg_r <= tcfg_s1_r;
		end
	end

	// ddr second half of each clock period
	always_ff @(negedge tx_bit_clock_input or negedge link_rst_n) begin
		if (!link_rst_n) begin
			neg_r <= 2'b00;
		end else begin
			neg_r <= {tx_strobe_input, tx_data_input};
		end
	end

	// pins sampled by the clock that launched them
	always_ff @(posedge tx_bit_clock_input or negedge link_rst_n) begin
		if (!link_rst_n) begin
			pos_r <= 2'b00;
		end else begin
			pos_r <= {tx_strobe_input, tx_data_input};
		end
	end

	cpsp_tap_if #(.W(4)) tx_tap ();
	assign tx_tap.din = {pos_r, neg_r};
	assign tx_tap.sel = tcfg_r[7:5];
	cpsp_tap_delay #(.W(4)) u_tx_dly (
		.clk   (tx_bit_clock_input),
		.rst_n (link_rst_n),
		.tap   (tx_tap)
	);

	// rising sample first, then the falling one in ddr
	always_comb begin
		des_a = des_step(des_r, tx_tap.dout[3], tx_tap.dout[2],
			tcfg_r[3], tcfg_r[1]);
		des_b = tcfg_r[4] ? des_step(des_a, tx_tap.dout[1],
			tx_tap.dout[0], tcfg_r[3], tcfg_r[1]) : des_a;
	end

	// frame tracking and pair rebuild
	always_ff @(posedge tx_bit_clock_input or negedge link_rst_n) begin
		if (!link_rst_n) begin
			des_r     <= '0;
			tx_word_r <= 32'h00000000;
			tx_tog_r  <= 1'b0;
		end else if (!tcfg_r[0]) begin
			des_r <= '0;
		end else begin
			des_r <= des_b;
			if (des_a.done | des_b.done) begin
				logic [31:0] w;
				logic [15:0] fw;
				logic [15:0] sw;
				w  = des_a.done ? des_a.sh : des_b.sh;
				fw = tcfg_r[2] ? rev16(w[31:16]) : w[31:16];
				sw = tcfg_r[2] ? rev16(w[15:0]) : w[15:0];
				tx_word_r <= tcfg_r[1] ? {sw, fw} : {fw, sw};
				tx_tog_r  <= ~tx_tog_r;
			end
		end
	end

	// toggle crossing; the word is stable for a whole frame
	logic [2:0] tsync_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tsync_r     <= 3'b000;
			txs_r       <= 32'h00000000;
			tx_frames_r <= 16'h0000;
		end else begin
			tsync_r <= {tsync_r[1:0], tx_tog_r};
			if (tsync_r[2] ^ tsync_r[1]) begin
				txs_r       <= tx_word_r;
				tx_frames_r <= tx_frames_r + 16'h0001;
			end
		end
	end

	// ---- checks ----
	logic [4:0] hi_ev_r;  // bit periods with strobe high
	logic [7:0] hcyc_r;   // cycles since clock edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hi_ev_r <= 5'h00;
			hcyc_r  <= 8'h00;
		end else begin
			hcyc_r <= (rx_tick || !rx_go) ? 8'h00 : hcyc_r + 8'h01;
			if (!rx_go) begin
				hi_ev_r <= 5'h00;
			end else if (rx_st_r == RX_OFF || rx_shift) begin
				hi_ev_r <= rx_stb_nxt ? hi_ev_r + 5'h01 : 5'h00;
			end
		end
	end

	property p_pulse_one;
		@(posedge hclk) disable iff (!hresetn)
		(rx_go && !ctrl_r[CTRL_RX_LVL] && rx_shift && rx_stb_q)
			|=> !rx_stb_q;
	endproperty
	a_pulse_one: assert property (p_pulse_one)
		else $error("pulse strobe longer than one bit");

	property p_level_len;
		@(posedge hclk) disable iff (!hresetn)
		(rx_go && $past(rx_go) && ctrl_r[CTRL_RX_LVL] && $stable(ctrl_r)
			&& $fell(rx_stb_q)) |-> ($past(hi_ev_r) == 5'h10);
	endproperty
	a_level_len: assert property (p_level_len)
		else $error("level strobe not sixteen bits high");

	property p_b2b;
		@(posedge hclk) disable iff (!hresetn)
		(rx_go && rx_shift && rx_idx_r == 5'h1f)
			|=> (rx_idx_r == 5'h00 && rx_st_r == RX_RUN);
	endproperty
	a_b2b: assert property (p_b2b)
		else $error("gap between receive frames");

	property p_first_bit;
		@(posedge hclk) disable iff (!hresetn)
		(rx_go && rx_shift && rx_idx_r == 5'h1f && $stable(ctrl_r))
			|=> rx_dat_q == ($past(ctrl_r[CTRL_RX_QF])
			? ($past(ctrl_r[CTRL_RX_LSB]) ? $past(rxs_r[0]) : $past(rxs_r[15]))
			: ($past(ctrl_r[CTRL_RX_LSB]) ? $past(rxs_r[16])
			: $past(rxs_r[31])));
	endproperty
	a_first_bit: assert property (p_first_bit)
		else $error("wrong first bit of receive frame");

	property p_sdr_edge;
		@(posedge hclk) disable iff (!hresetn)
		// the first bit after enable is loaded from idle, not on an edge
		(rx_go && $past(rx_go) && $past(rx_st_r == RX_RUN)
			&& !ctrl_r[CTRL_RX_DDR] && $changed(rx_dat_q))
			|-> ($past(rx_clk_r) && !rx_clk_r);
	endproperty
	a_sdr_edge: assert property (p_sdr_edge)
		else $error("sdr data moved off the falling edge");

	property p_pads;
		@(posedge hclk) disable iff (!hresetn)
		(ctrl_r[CTRL_LVDS])[*2] |-> !rx_bit_clock_output
			&& !rx_strobe_output && !rx_data_output
			&& !tx_reference_clock_output;
	endproperty
	a_pads: assert property (p_pads)
		else $error("cmos outputs active in lvds mode");

	property p_half_min;
		@(posedge hclk) disable iff (!hresetn)
		(rx_tick && $past(rx_go)) |-> (hcyc_r >= HALF_MIN - 8'h01);
	endproperty
	a_half_min: assert property (p_half_min)
		else $error("port clock above its limit");

	property p_ref_off;
		@(posedge hclk) disable iff (!hresetn)
		(!ctrl_r[CTRL_REF_EN])[*2] |-> !tx_reference_clock_output;
	endproperty
	a_ref_off: assert property (p_ref_off)
		else $error("reference clock running while disabled");

	property p_tx_tog;
		@(posedge tx_bit_clock_input) disable iff (!link_rst_n)
		(tcfg_r[0] && (des_a.done || des_b.done)) |=> $changed(tx_tog_r);
	endproperty
	a_tx_tog: assert property (p_tx_tog)
		else $error("rebuilt pair not handed over");
endmodule : cpsp_top
